// ==== core/fsled_top.sv ====
// Purpose: Drives the two link/activity indicators and the run indicator.
// Assumes: Link, activity and state inputs are synchronous to clk_i.
// Notes: Pattern periods are parameters so a simulation can shorten them.
// Operation
// - Upstream indicator dark without incoming link.
// - Upstream indicator steady with idle link.
// - Upstream indicator flashes during traffic.
// - Downstream indicator dark without outgoing link.
// - Downstream indicator steady with idle link.
// - Downstream indicator flashes during traffic.
// - Run indicator dark in INIT.
// - Run indicator flashes in PREOP.
// - Run indicator single flash in SAFEOP.
// - Run indicator steady in OP.
// - Run indicator flickers in BOOTSTRAP.
`include "fsled_map.svh"
module fsled_top #(
  parameter int unsigned FLASH_ON_CYC = `FSLED_MS_CYC(`FSLED_FLASH_ON_MS),
  parameter int unsigned FLASH_OFF_CYC = `FSLED_MS_CYC(`FSLED_FLASH_OFF_MS),
  parameter int unsigned SINGLE_ON_CYC = `FSLED_MS_CYC(`FSLED_SINGLE_ON_MS),
  parameter int unsigned SINGLE_OFF_CYC = `FSLED_MS_CYC(`FSLED_SINGLE_OFF_MS),
  parameter int unsigned FLICK_ON_CYC = `FSLED_MS_CYC(`FSLED_FLICK_ON_MS),
  parameter int unsigned FLICK_OFF_CYC = `FSLED_MS_CYC(`FSLED_FLICK_OFF_MS)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Port status from the physical layer
  input wire fsled_pkg::fsled_port_t upstream_port_i,
  input wire fsled_pkg::fsled_port_t downstream_port_i,
  // Slave state machine state code
  input wire logic [2:0] run_state_i,
  // Indicators, high means lit
  output logic upstream_link_activity_indicator_o,
  output logic downstream_link_activity_indicator_o,
  output logic run_indicator_o
);
  import fsled_pkg::*;

  localparam int CW = 24;

  // ----------------------------------------------------------------
  // Pattern generators
  // ----------------------------------------------------------------
  // Free-running generators time the run indicator; the link indicators use their own per-port sequencers.
  logic [CW-1:0] fl_cnt_r, fl_cnt_nxt, sg_cnt_r, sg_cnt_nxt, fk_cnt_r, fk_cnt_nxt;
  logic fl_on_r, fl_on_nxt, sg_on_r, sg_on_nxt, fk_on_r, fk_on_nxt;

  function automatic logic [CW:0] step(input logic [CW-1:0] cnt, input logic on,
                                       input int unsigned on_cyc, input int unsigned off_cyc);
    logic [CW-1:0] lim;
    lim = on ? CW'(on_cyc - 1) : CW'(off_cyc - 1);
    if (cnt >= lim) begin
      step = {~on, {CW{1'b0}}};
    end else begin
      step = {on, CW'(cnt + 1'b1)};
    end
  endfunction

  always_comb begin
    {fl_on_nxt, fl_cnt_nxt} = step(fl_cnt_r, fl_on_r, FLASH_ON_CYC, FLASH_OFF_CYC);
    {sg_on_nxt, sg_cnt_nxt} = step(sg_cnt_r, sg_on_r, SINGLE_ON_CYC, SINGLE_OFF_CYC);
    {fk_on_nxt, fk_cnt_nxt} = step(fk_cnt_r, fk_on_r, FLICK_ON_CYC, FLICK_OFF_CYC);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fl_cnt_r <= '0;
      sg_cnt_r <= '0;
      fk_cnt_r <= '0;
      fl_on_r <= 1'b1;
      sg_on_r <= 1'b1;
      fk_on_r <= 1'b1;
    end else begin
      fl_cnt_r <= fl_cnt_nxt;
      sg_cnt_r <= sg_cnt_nxt;
      fk_cnt_r <= fk_cnt_nxt;
      fl_on_r <= fl_on_nxt;
      sg_on_r <= sg_on_nxt;
      fk_on_r <= fk_on_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Link/activity indicators
  // ----------------------------------------------------------------
  // Each port owns a flash sequencer: an activity pulse starts a full
  // on/off cycle that runs to completion while the link holds; any frames during a flash add one more flash at most.
  fsled_port_t prt [2];
  assign prt[0] = upstream_port_i;
  assign prt[1] = downstream_port_i;
  logic [1:0] led_r, led_nxt;

  for (genvar g = 0; g < 2; g++) begin : g_port
    fsled_phase_t ph_r, ph_nxt;
    logic [CW-1:0] c_r, c_nxt;
    logic pend_r, pend_nxt;
    logic lit_nxt;

    always_comb begin
      ph_nxt = ph_r;
      c_nxt = c_r;
      pend_nxt = pend_r | prt[g].act;
      case (ph_r)
        FSLED_PH_IDLE: begin
          if (pend_r || prt[g].act) begin
            ph_nxt = FSLED_PH_ON;
            c_nxt = '0;
            pend_nxt = 1'b0;
          end
        end
        FSLED_PH_ON: begin
          if (c_r >= CW'(FLASH_ON_CYC - 1)) begin
            ph_nxt = FSLED_PH_OFF;
            c_nxt = '0;
          end else begin
            c_nxt = CW'(c_r + 1'b1);
          end
        end
        FSLED_PH_OFF: begin
          if (c_r >= CW'(FLASH_OFF_CYC - 1)) begin
            ph_nxt = FSLED_PH_IDLE;
            c_nxt = '0;
          end else begin
            c_nxt = CW'(c_r + 1'b1);
          end
        end
        default: begin
          ph_nxt = FSLED_PH_IDLE;
          c_nxt = '0;
        end
      endcase
      // Losing the link drops any pending traffic display at once.
      if (!prt[g].link) begin
        ph_nxt = FSLED_PH_IDLE;
        c_nxt = '0;
        pend_nxt = 1'b0;
      end
      if (!prt[g].link) begin
        lit_nxt = 1'b0;
      end else if (ph_r == FSLED_PH_OFF) begin
        lit_nxt = 1'b0;
      end else begin
        lit_nxt = 1'b1;
      end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        ph_r <= FSLED_PH_IDLE;
        c_r <= '0;
        pend_r <= 1'b0;
      end else begin
        ph_r <= ph_nxt;
        c_r <= c_nxt;
        pend_r <= pend_nxt;
      end
    end
  end

  // One driver for the whole vector, so neither port process owns a slice of it.
  assign led_nxt = {g_port[1].lit_nxt, g_port[0].lit_nxt};

  // ----------------------------------------------------------------
  // Run indicator
  // ----------------------------------------------------------------
  logic run_nxt, run_r;

  always_comb begin
    case (run_state_i)
      `FSLED_ST_INIT: run_nxt = 1'b0;
      `FSLED_ST_PREOP: run_nxt = fl_on_r;
      `FSLED_ST_SAFEOP: run_nxt = sg_on_r;
      `FSLED_ST_OP: run_nxt = 1'b1;
      `FSLED_ST_BOOT: run_nxt = fk_on_r;
      default: run_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      led_r <= 2'h0;
      run_r <= 1'b0;
    end else begin
      led_r <= led_nxt;
      run_r <= run_nxt;
    end
  end

  assign upstream_link_activity_indicator_o = led_r[0];
  assign downstream_link_activity_indicator_o = led_r[1];
  assign run_indicator_o = run_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_up_dark;
    @(posedge clk_i) disable iff (!nrst_i)
      !upstream_port_i.link |=> !upstream_link_activity_indicator_o;
  endproperty
  a_up_dark: assert property (p_up_dark) else $error("upstream lit without link");

  property p_up_steady;
    @(posedge clk_i) disable iff (!nrst_i)
      (upstream_port_i.link && g_port[0].ph_r == FSLED_PH_IDLE)
        |=> upstream_link_activity_indicator_o;
  endproperty
  a_up_steady: assert property (p_up_steady) else $error("upstream idle link dark");

  sequence s_up_burst;
    upstream_port_i.link && upstream_port_i.act && g_port[0].ph_r == FSLED_PH_IDLE;
  endsequence
  property p_up_flash;
    @(posedge clk_i) disable iff (!nrst_i)
      s_up_burst ##1 upstream_port_i.link [*2] |=> upstream_link_activity_indicator_o;
  endproperty
  a_up_flash: assert property (p_up_flash) else $error("upstream flash not lit");

  property p_dn_dark;
    @(posedge clk_i) disable iff (!nrst_i)
      !downstream_port_i.link |=> !downstream_link_activity_indicator_o;
  endproperty
  a_dn_dark: assert property (p_dn_dark) else $error("downstream lit without link");

  property p_dn_steady;
    @(posedge clk_i) disable iff (!nrst_i)
      (downstream_port_i.link && g_port[1].ph_r != FSLED_PH_OFF)
        |=> downstream_link_activity_indicator_o;
  endproperty
  a_dn_steady: assert property (p_dn_steady) else $error("downstream link dark");

  property p_dn_flash;
    @(posedge clk_i) disable iff (!nrst_i)
      (downstream_port_i.link && g_port[1].ph_r == FSLED_PH_OFF)
        |=> !downstream_link_activity_indicator_o;
  endproperty
  a_dn_flash: assert property (p_dn_flash) else $error("downstream off phase lit");

  property p_run_init;
    @(posedge clk_i) disable iff (!nrst_i)
      run_state_i == `FSLED_ST_INIT |=> !run_indicator_o;
  endproperty
  a_run_init: assert property (p_run_init) else $error("run lit in init");

  property p_run_op;
    @(posedge clk_i) disable iff (!nrst_i)
      run_state_i == `FSLED_ST_OP |=> run_indicator_o;
  endproperty
  a_run_op: assert property (p_run_op) else $error("run dark in op");

  property p_run_pat;
    @(posedge clk_i) disable iff (!nrst_i)
      (run_state_i == `FSLED_ST_PREOP |=> run_indicator_o == $past(fl_on_r)) and
      (run_state_i == `FSLED_ST_SAFEOP |=> run_indicator_o == $past(sg_on_r)) and
      (run_state_i == `FSLED_ST_BOOT |=> run_indicator_o == $past(fk_on_r));
  endproperty
  a_run_pat: assert property (p_run_pat) else $error("run pattern mismatch");

  property p_flick_len;
    @(posedge clk_i) disable iff (!nrst_i)
      $rose(fk_on_r) |-> fk_on_r [*2];
  endproperty
  a_flick_len: assert property (p_flick_len) else $error("flicker on phase short");

  property p_stretch;
    @(posedge clk_i) disable iff (!nrst_i)
      (g_port[0].ph_r == FSLED_PH_IDLE && upstream_port_i.act && upstream_port_i.link)
        |=> g_port[0].ph_r == FSLED_PH_ON;
  endproperty
  a_stretch: assert property (p_stretch) else $error("activity pulse lost");
endmodule

// ==== dv/fsled_peer_model.sv ====
// Purpose: Model of the neighbouring node on one fieldbus port.
// Assumes: Bench requests change just after clk_i rises.
// Notes: Each requested frame shows as a one-cycle activity pulse.
// ----------------------------------------
// Peer node
// ----------------------------------------
module fsled_peer_model (
  // Clock
  input wire logic clk_i,
  // Requests from the bench
  input wire logic link_i,
  input wire logic frame_i,
  // Port status towards the design
  output fsled_pkg::fsled_port_t port_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import fsled_pkg::*;
  initial port_o = '0;
  // Activity is sent even with the link down, so the design must discard it.
  always @(posedge clk_i) begin
    port_o.link <= link_i;
    port_o.act <= frame_i;
  end
endmodule

// ==== dv/fsled_top_test.sv ====
// Purpose: Self-checking bench for the status indicator driver.
// Assumes: Short pattern periods of 4/4, 4/12 and 2/2 cycles.
// Notes: Run patterns are judged over whole periods, so phase does not matter.
`include "fsled_map.svh"
module fsled_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import fsled_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [2:0] run_state_i = 3'h1;
  logic up_link = 1'b0;
  logic up_frame = 1'b0;
  logic dn_link = 1'b0;
  logic dn_frame = 1'b0;
  fsled_port_t up_port;
  fsled_port_t dn_port;
  logic up_led;
  logic dn_led;
  logic run_led;
  int mismatches = 0;
  int compares = 0;
  // Short pattern periods keep the whole run well inside the watchdog limit.
  localparam int unsigned FLASH_CYC = 4;
  localparam int unsigned FLICK_CYC = FLASH_CYC / 2;
  localparam int unsigned LONG_OFF_CYC = 3 * FLASH_CYC;
  always #50 clk_i = ~clk_i;
  fsled_peer_model up_peer (.clk_i(clk_i), .link_i(up_link), .frame_i(up_frame),
    .port_o(up_port));
  fsled_peer_model dn_peer (.clk_i(clk_i), .link_i(dn_link), .frame_i(dn_frame),
    .port_o(dn_port));
  fsled_top #(.FLASH_ON_CYC(FLASH_CYC), .FLASH_OFF_CYC(FLASH_CYC),
    .SINGLE_ON_CYC(FLASH_CYC), .SINGLE_OFF_CYC(LONG_OFF_CYC),
    .FLICK_ON_CYC(FLICK_CYC), .FLICK_OFF_CYC(FLICK_CYC)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .upstream_port_i(up_port), .downstream_port_i(dn_port), .run_state_i(run_state_i),
    .upstream_link_activity_indicator_o(up_led),
    .downstream_link_activity_indicator_o(dn_led), .run_indicator_o(run_led));

  task automatic check_count(input string what, input int got, input int exp);
    compares++;
    if (got != exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic check_level(input string what, input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  function automatic logic pick(input int sel);
    return (sel == 0) ? up_led : ((sel == 1) ? dn_led : run_led);
  endfunction
  // Counts lit cycles and changes; an unknown level is a mismatch of its own.
  task automatic measure(input int sel, input int n, output int highs, output int toggles);
    logic prev;
    logic cur;
    highs = 0;
    toggles = 0;
    @(negedge clk_i);
    prev = pick(sel);
    repeat (n) begin
      @(negedge clk_i);
      cur = pick(sel);
      if ($isunknown(cur)) begin
        mismatches++;
        $display("mismatch at %0t: unknown indicator level", $time);
      end
      highs += int'(cur === 1'b1);
      toggles += int'(cur !== prev);
      prev = cur;
    end
  endtask
  task automatic drive(input int sel, input logic link, input logic frame);
    @(posedge clk_i);
    if (sel == 0) begin
      up_link <= link;
      up_frame <= frame;
    end else begin
      dn_link <= link;
      dn_frame <= frame;
    end
  endtask

  task automatic port_test(input int sel);
    int h;
    int t;
    drive(sel, 1'b0, 1'b0);
    repeat (4) @(posedge clk_i);
    measure(sel, 20, h, t);
    check_count("dark", h, 0);
    drive(sel, 1'b1, 1'b0);
    repeat (4) @(posedge clk_i);
    measure(sel, 20, h, t);
    check_count("steady", h, 20);
    drive(sel, 1'b1, 1'b1);
    drive(sel, 1'b1, 1'b0);
    measure(sel, 20, h, t);
    check_count("one flash dark", 20 - h, 4);
    drive(sel, 1'b1, 1'b1);
    drive(sel, 1'b1, 1'b0);
    drive(sel, 1'b1, 1'b1);
    drive(sel, 1'b1, 1'b0);
    measure(sel, 30, h, t);
    check_count("two flashes dark", 30 - h, 8);
    drive(sel, 1'b0, 1'b1);
    drive(sel, 1'b1, 1'b0);
    measure(sel, 20, h, t);
    check_count("no flash dark", 20 - h, 1);
    drive(sel, 1'b1, 1'b1);
    drive(sel, 1'b0, 1'b0);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    check_level("aborted", pick(sel), 1'b0);
  endtask

  task automatic run_test();
    logic [2:0] codes [6] = '{`FSLED_ST_INIT, `FSLED_ST_PREOP, `FSLED_ST_SAFEOP,
      `FSLED_ST_OP, `FSLED_ST_BOOT, 3'h7};
    int exp_h [6] = '{0, 80, 40, 160, 80, 0};
    int exp_t [6] = '{0, 40, 20, 0, 80, 0};
    int h;
    int t;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      run_state_i <= codes[i];
      repeat (3) @(posedge clk_i);
      measure(2, 160, h, t);
      check_count("run lit", h, exp_h[i]);
      check_count("run changes", t, exp_t[i]);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    check_level("reset dark", up_led | dn_led | run_led, 1'b0);
    nrst_i <= 1'b1;
    port_test(0);
    port_test(1);
    run_test();
    print_verdict();
  end
  // The tests need about 1300 cycles, so this limit only trips on a hang.
  initial begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule

// ==== pkg/fsled_map.svh ====
// Purpose: Constants for the status indicator driver.
// Assumes: 10 MHz system clock.
// Notes: Times are in milliseconds; cycle counts derive from them.
`ifndef FSLED_MAP_SVH
`define FSLED_MAP_SVH
`define FSLED_CLK_HZ 10000000
`define FSLED_FLASH_ON_MS 200
`define FSLED_FLASH_OFF_MS 200
`define FSLED_SINGLE_ON_MS 200
`define FSLED_SINGLE_OFF_MS 1000
`define FSLED_FLICK_ON_MS 50
`define FSLED_FLICK_OFF_MS 50
`define FSLED_MS_CYC(ms) (((ms) * (`FSLED_CLK_HZ / 1000)))
`define FSLED_ST_INIT 3'h1
`define FSLED_ST_PREOP 3'h2
`define FSLED_ST_BOOT 3'h3
`define FSLED_ST_SAFEOP 3'h4
`define FSLED_ST_OP 3'h5
`endif

// ==== pkg/fsled_pkg.sv ====
// Purpose: Types for the status indicator driver.
// Assumes: Nothing beyond the map header.
// Notes: The port struct groups the per-port link and activity inputs.
package fsled_pkg;
  typedef struct packed {
    logic link;
    logic act;
  } fsled_port_t;
  typedef enum logic [1:0] {
    FSLED_PH_IDLE = 2'h0,
    FSLED_PH_ON = 2'h1,
    FSLED_PH_OFF = 2'h3
  } fsled_phase_t;
endpackage
